/* File: bench/charger_regs_monitor.sv */
`timescale 1ns/1ns
module charger_regs_monitor
  import charger_regs_pkg::*;
#(parameter int adc_cycles_p = 4) (
  // Bus
  input wire logic        hclk, hresetn, hsel, hwrite, hready,
  input wire logic        hreadyout, hresp,
  input wire logic [31:0] haddr, hwdata, hrdata,
  input wire logic [1:0]  htrans,
  input wire logic [2:0]  hsize,
  // Pins and controls
  input wire logic        dedicated_port_mode_pin, buck_enable_pin,
  input wire logic [2:0]  usb_current_limit,
  input wire logic [1:0]  retry_timer_select, charge_detect_config,
  input wire logic [1:0]  source_current_advert,
  input wire logic        typec_detect_disable, buck_run, adc_start,
  input wire logic        force_error_request, source_restart_request
);
  wire       wr = hsel && htrans[1] && hready && hwrite;
  wire       rd = hsel && htrans[1] && hready && !hwrite;
  wire [7:0] a  = haddr[7:0];
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_lim;
    $changed(usb_current_limit) |-> $past(wr && a == off_current_limit, 2);
  endproperty
  a_lim: assert property (p_lim) else $error("limit moved unwritten");
  property p_setup;
    $changed({retry_timer_select, typec_detect_disable,
      source_current_advert}) |-> $past(wr && a == off_retry_setup, 2);
  endproperty
  a_setup: assert property (p_setup) else $error("setup moved");
  property p_cd;
    $rose(hresetn) |->
      ##2 charge_detect_config == {1'b1, dedicated_port_mode_pin};
  endproperty
  a_cd: assert property (p_cd) else $error("bad detect preload");
  property p_fe;
    force_error_request |->
      $past(wr && a == off_state_req, 2) && $past(hwdata[1]);
  endproperty
  a_fe: assert property (p_fe) else $error("stray error request");
  property p_rs;
    source_restart_request |->
      $past(wr && a == off_state_req, 2) && $past(hwdata[0]);
  endproperty
  a_rs: assert property (p_rs) else $error("stray restart");
  property p_rd;
    rd && a == off_state_req |=> hrdata[1:0] == 2'b00;
  endproperty
  a_rd: assert property (p_rd) else $error("request bits read");
  property p_buck;
    buck_run |-> $past(buck_enable_pin);
  endproperty
  a_buck: assert property (p_buck) else $error("buck pin low");
  property p_adc;
    adc_start |=> !adc_start [*3];
  endproperty
  a_adc: assert property (p_adc) else $error("sample restarted");
  c_fe: cover property (force_error_request);
  c_buck: cover property (buck_run);
  c_adc: cover property (adc_start);
endmodule : charger_regs_monitor

bind charger_setup_request_regs charger_regs_monitor
  #(.adc_cycles_p(adc_cycles_p)) mon_u (.*);

/* File: bench/tb_charger_setup_request_regs.sv */
`timescale 1ns/1ns
module tb_charger_setup_request_regs
  import charger_regs_pkg::*;
;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, d;
  logic [1:0] htrans = 0, retry_timer_select, charge_detect_config;
  logic [1:0] source_current_advert;
  logic [2:0] hsize = 3'h2, usb_current_limit;
  logic hreadyout, hresp, dedicated_port_mode_pin = 0, buck_enable_pin = 0;
  logic typec_detect_disable, buck_run, adc_start, rd_dp = 0;
  logic force_error_request, source_restart_request;
  wire hready = hreadyout;
  int err_count = 0, checks_done = 0, k;
  logic [31:0] exp_q[$];
  always #4 hclk = ~hclk;
  charger_setup_request_regs #(.adc_cycles_p(4)) dut_u (.*);
  task check(string n, logic [31:0] s, logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask : check
  task end_sim;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task xfer(logic [7:0] a, logic w, logic [31:0] v);
    @(posedge hclk);
    hsel <= 1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 0; htrans <= 0; hwdata <= v;
    do @(posedge hclk); while (hready !== 1'b1);
  endtask : xfer
  task rd(logic [7:0] a, logic [31:0] e);
    exp_q.push_back(e);
    xfer(a, 0, 0);
  endtask : rd
  task bk(logic e);
    repeat (2) @(posedge hclk);
    #1 check("buck_run", buck_run, e);
  endtask : bk
  always @(posedge hclk) begin
    if (rd_dp) check("hrdata", hrdata, exp_q.pop_front());
    rd_dp = hsel && htrans[1] && !hwrite && hready;
  end
  initial begin
    #100000;
    err_count++;
    end_sim();
  end
  initial begin
    d = $urandom(32'h09f22546);
    dedicated_port_mode_pin = d[0];
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    buck_enable_pin <= 1;
    rd(off_current_limit, 7);
    rd(off_retry_setup, {2'b11, 1'b1, d[0], 4'b0001});
    rd(off_config_done, 0);
    rd(off_converter, 32'h20);
    bk(0);
    for (int i = 0; i < 8; i++) begin
      xfer(off_current_limit, 1, i);
      #1 check("limit", usb_current_limit, i);
      rd(off_current_limit, i);
    end
    for (int i = 0; i < 4; i++) begin
      d = {i[1:0], 1'b1, i[0], i[0], 1'b0, i[1:0]};
      xfer(off_retry_setup, 1, d);
      #1 check("setup", {retry_timer_select, charge_detect_config,
        typec_detect_disable, source_current_advert},
        d[7:3] << 2 | i[1:0]);
      rd(off_retry_setup, d);
    end
    d = $urandom;
    xfer(off_current_limit, 1, d);
    rd(off_current_limit, d[2:0]);
    xfer(off_config_done, 1, 1);
    bk(1);
    check("ready_resp", {hreadyout, hresp}, 2);
    @(posedge hclk) buck_enable_pin <= 0;
    bk(0);
    @(posedge hclk) buck_enable_pin <= 1;
    xfer(off_converter, 1, 0);
    bk(0);
    xfer(off_state_req, 1, 3);
    #1 check("req", {force_error_request, source_restart_request}, 3);
    @(posedge hclk);
    #1 check("req", {force_error_request, source_restart_request}, 0);
    xfer(off_state_req, 1, 1);
    #1 check("req", {force_error_request, source_restart_request}, 1);
    rd(off_state_req, 0);
    xfer(off_sample_req, 1, 1);
    #1 k = 0;
    while (adc_start !== 1'b1 && k < 4) begin
      @(posedge hclk);
      #1 k++;
    end
    check("adc_start", adc_start, 1);
    repeat (8) @(posedge hclk);
    rd(off_sample_req, 2);
    @(posedge hclk) hresetn <= 0;
    dedicated_port_mode_pin <= ~dedicated_port_mode_pin;
    repeat (2) @(posedge hclk);
    hresetn <= 1;
    rd(off_retry_setup, {2'b11, 1'b1, dedicated_port_mode_pin, 4'b0001});
    xfer(8'h40, 1, 32'hff);
    rd(8'h40, 0);
    repeat (3) @(posedge hclk);
    end_sim();
  end
endmodule : tb_charger_setup_request_regs

/* File: rtl/ahb_lite_front.sv */
`timescale 1ns/1ns
module ahb_lite_front (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  // Register side
  ahb_req_if.slave         req
);
  logic       pend_wr_ff;
  logic [7:0] pend_addr_ff;
  wire        take = hsel & htrans[1] & hready;
  wire        ok   = (hsize == 3'h2) & (haddr[1:0] == 2'h0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_wr_ff   <= 1'b0;
      pend_addr_ff <= 8'h00;
    end else begin
      pend_wr_ff   <= take & hwrite & ok;
      pend_addr_ff <= take ? haddr[7:0] : pend_addr_ff;
    end
  end

  assign req.wr    = pend_wr_ff;
  assign req.rd    = take & ~hwrite;
  assign req.addr  = haddr[7:0];
  assign req.waddr = pend_addr_ff;
  assign req.wdata = hwdata;
endmodule : ahb_lite_front

/* File: rtl/ahb_req_if.sv */
`timescale 1ns/1ns
interface ahb_req_if;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [7:0]  waddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport slave  (output wr, rd, addr, waddr, wdata, input rdata);
  modport regs   (input wr, rd, addr, waddr, wdata, output rdata);
endinterface : ahb_req_if

/* File: rtl/charger_regs_pkg.sv */
// Overview of operation
// - Three-bit field picks USB DC current limit, 0.3 A up to 3.04 A.
// - Retry timer bits 7:6: 2.0 s, 1.0 s, 0.5 s, 16 ms.
// - Startup loads charge-detect field 0b10 or 0b11 from the mode pin.
// - Charge-detect bits 5:4: 00/01 reserved, 10 is 2.4A, 11 is 1.0A.
// - Bit 3 set turns Type-C detection off, legacy Type-A only.
// - Advertisement bits 1:0: 0.5A, 1.5A, 3.0A, 11 gives 0.5A.
// - Writing 1 to force-error drives Type-C machine to error recovery.
// - Writing 1 to source-restart forces Type-C back to unattached source.
// - Force-error bit is write-only and always reads zero.
// - Source-restart bit is write-only and always reads zero.
// - Converter enable bit is ANDed with the buck enable pin and the config-done bit.
package charger_regs_pkg;
  localparam logic [7:0] off_current_limit = 8'h08;
  localparam logic [7:0] off_retry_setup   = 8'h0c;
  localparam logic [7:0] off_config_done   = 8'h10;
  localparam logic [7:0] off_sample_req    = 8'h14;
  localparam logic [7:0] off_state_req     = 8'h18;
  localparam logic [7:0] off_converter     = 8'h20;

  localparam int usb_current_limit_lsb       = 0;
  localparam int retry_lsb      = 6;
  localparam int cd_lsb         = 4;
  localparam int detect_dis_bit = 3;
  localparam int advert_lsb     = 0;
  localparam int configured_bit = 0;
  localparam int sample_bit     = 0;
  localparam int sample_rdy_bit = 1;
  localparam int force_err_bit  = 1;
  localparam int restart_bit    = 0;
  localparam int conv_en_bit    = 5;

  localparam logic [2:0] usb_current_limit_reset   = 3'h7;
  localparam logic [1:0] retry_reset  = 2'h3;
  localparam logic [1:0] advert_reset = 2'h1;
  localparam logic [1:0] cd_mode0     = 2'h2;
  localparam logic [1:0] cd_mode1     = 2'h3;
  localparam logic       conv_reset   = 1'b1;

  // Sample done after a fixed conversion time
  localparam int adc_time_ns  = 1000;
  localparam int clk_ns       = 8;
  localparam int adc_cycles   = adc_time_ns / clk_ns;
endpackage : charger_regs_pkg

/* File: rtl/charger_setup_request_regs.sv */
`timescale 1ns/1ns
module charger_setup_request_regs
  import charger_regs_pkg::*;
#(
  parameter int adc_cycles_p = adc_cycles
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Pins and device controls
  input  wire logic        dedicated_port_mode_pin,
  input  wire logic        buck_enable_pin,
  output logic      [2:0]  usb_current_limit,
  output logic      [1:0]  retry_timer_select,
  output logic      [1:0]  charge_detect_config,
  output logic             typec_detect_disable,
  output logic      [1:0]  source_current_advert,
  output logic             buck_run,
  output logic             force_error_request,
  output logic             source_restart_request,
  output logic             adc_start
);
  if (adc_cycles_p < 1 || adc_cycles_p > 65535) begin : g_bad_cycles
    $error("adc_cycles_p out of range");
  end

  ahb_req_if req ();

  ahb_lite_front u_front (
    .hclk    (hclk),
    .hresetn (hresetn),
    .hsel    (hsel),
    .haddr   (haddr),
    .htrans  (htrans),
    .hwrite  (hwrite),
    .hsize   (hsize),
    .hwdata  (hwdata),
    .hready  (hready),
    .req     (req)
  );

  typedef enum logic [1:0] {adc_idle, adc_busy} adc_state_t;

  logic [2:0]  usb_current_limit_ff;
  logic [1:0]  retry_ff;
  logic [1:0]  cd_ff;
  logic        dis_ff;
  logic [1:0]  adv_ff;
  logic        cfg_ff;
  logic        conv_ff;
  logic        smp_ff;
  logic        rdy_ff;
  logic        strap_done_ff;
  adc_state_t  adc_ff;
  logic [15:0] cnt_ff;
  logic [31:0] rdata_ff;
  logic        buck_ff;
  logic        ferr_ff;
  logic        srst_ff;
  logic        start_ff;
  logic        rdy_out_ff;
  logic        resp_ff;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  wire w_usb_current_limit  = req.wr & hit(req.waddr, off_current_limit);
  wire w_retry = req.wr & hit(req.waddr, off_retry_setup);
  wire w_cfg   = req.wr & hit(req.waddr, off_config_done);
  wire w_smp   = req.wr & hit(req.waddr, off_sample_req);
  wire w_state = req.wr & hit(req.waddr, off_state_req);
  wire w_conv  = req.wr & hit(req.waddr, off_converter);
  wire [31:0] d = req.wdata;
  wire smp_go  = w_smp & d[sample_bit];
  wire cnt_end = (cnt_ff == 16'(adc_cycles_p - 1));

  // Read mux
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0;
    case (req.addr)
      off_current_limit: rmux[usb_current_limit_lsb +: 3] = usb_current_limit_ff;
      off_retry_setup: begin
        rmux[retry_lsb +: 2]    = retry_ff;
        rmux[cd_lsb +: 2]       = cd_ff;
        rmux[detect_dis_bit]    = dis_ff;
        rmux[advert_lsb +: 2]   = adv_ff;
      end
      off_config_done: rmux[configured_bit] = cfg_ff;
      off_sample_req: begin
        rmux[sample_bit]     = smp_ff;
        rmux[sample_rdy_bit] = rdy_ff;
      end
      off_state_req: rmux = 32'h0;
      off_converter: rmux[conv_en_bit] = conv_ff;
      default: rmux = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      usb_current_limit_ff  <= usb_current_limit_reset;
      retry_ff <= retry_reset;
      cd_ff    <= cd_mode0;
      dis_ff   <= 1'b0;
      adv_ff   <= advert_reset;
      cfg_ff   <= 1'b0;
      conv_ff  <= conv_reset;
      strap_done_ff <= 1'b0;
    end else begin
      strap_done_ff <= 1'b1;
      if (!strap_done_ff)
        cd_ff <= dedicated_port_mode_pin ? cd_mode1 : cd_mode0;
      else if (w_retry)
        cd_ff <= d[cd_lsb +: 2];
      if (w_usb_current_limit)
        usb_current_limit_ff <= d[usb_current_limit_lsb +: 3];
      if (w_retry) begin
        retry_ff <= d[retry_lsb +: 2];
        dis_ff   <= d[detect_dis_bit];
        adv_ff   <= d[advert_lsb +: 2];
      end
      if (w_cfg)
        cfg_ff <= d[configured_bit];
      if (w_conv)
        conv_ff <= d[conv_en_bit];
    end
  end

  // Sample request and conversion timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_ff   <= adc_idle;
      cnt_ff   <= 16'h0;
      smp_ff   <= 1'b0;
      rdy_ff   <= 1'b0;
      start_ff <= 1'b0;
    end else begin
      start_ff <= smp_go & (adc_ff == adc_idle);
      case (adc_ff)
        adc_idle: begin
          cnt_ff <= 16'h0;
          if (smp_go) begin
            adc_ff <= adc_busy;
            smp_ff <= 1'b1;
            rdy_ff <= 1'b0;
          end
        end
        adc_busy: begin
          cnt_ff <= cnt_ff + 16'h1;
          if (cnt_end) begin
            adc_ff <= adc_idle;
            smp_ff <= 1'b0;
            rdy_ff <= 1'b1;
          end
        end
        default: adc_ff <= adc_idle;
      endcase
    end
  end

  // Outputs and request pulses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff   <= 32'h0;
      buck_ff    <= 1'b0;
      ferr_ff    <= 1'b0;
      srst_ff    <= 1'b0;
      rdy_out_ff <= 1'b1;
      resp_ff    <= 1'b0;
    end else begin
      rdy_out_ff <= 1'b1;
      resp_ff    <= 1'b0;
      rdata_ff <= req.rd ? rmux : rdata_ff;
      buck_ff  <= conv_ff & buck_enable_pin & cfg_ff;
      ferr_ff  <= w_state & d[force_err_bit];
      srst_ff  <= w_state & d[restart_bit];
    end
  end

  assign req.rdata             = rmux;
  assign hrdata                = rdata_ff;
  assign hreadyout             = rdy_out_ff;
  assign hresp                 = resp_ff;
  assign usb_current_limit     = usb_current_limit_ff;
  assign retry_timer_select    = retry_ff;
  assign charge_detect_config  = cd_ff;
  assign typec_detect_disable  = dis_ff;
  assign source_current_advert = adv_ff;
  assign buck_run              = buck_ff;
  assign force_error_request   = ferr_ff;
  assign source_restart_request = srst_ff;
  assign adc_start             = start_ff;
endmodule : charger_setup_request_regs
